// file: logic/t2c_timer.sv
// Timer two: 16-bit capture/reload timer with control register on classic Wishbone
//
// Register access over Wishbone was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "t2c_defs.svh"

// Behaviour
// - Overflow sets overflow flag unless a serial clock select is high.
// - Overflow flag is never cleared by hardware, only by software write.
// - Enabled trigger falling edge causing capture or reload sets external flag.
// - External flag stays set until software clears it.
// - Receive clock select picks this timer or other timer overflow for receive.
// - Transmit clock select picks this timer or other timer overflow for transmit.
// - Trigger enable with both selects low makes falling edges act; else ignored.
// - Timer mode counts every 2 clocks; counter mode on count pin falls.
// - Select low reloads on overflow or trigger; high captures on trigger.
// - Either serial clock select forces reload on every overflow.
// - Reload/capture value is a software readable, writable 16-bit byte pair.
module t2c_timer
    import t2c_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`T2C_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Pins and neighbouring timer
    input wire logic count_pin_i,
    input wire logic trigger_pin_i,
    input wire logic timer1_ovf_i,
    // Serial port clocks and flag levels
    output logic rx_baud_tick_o,
    output logic tx_baud_tick_o,
    output logic overflow_flag_o,
    output logic external_edge_flag_o
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    t2c_ctrl_t ctrl_q;
    t2c_ctrl_t ctrl_d;
    t2c_ctrl_t ctrl_wr;
    t2c_baud_t baud_q;
    t2c_baud_t baud_d;
    logic [15:0] count_q;
    logic [15:0] count_d;
    logic [15:0] count_nx;
    logic [15:0] rcap_q;
    logic [15:0] rcap_d;
    logic [31:0] rdat_d;
    logic ack_q;
    logic pre_q;
    logic cnt_pin_q;
    logic trg_pin_q;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    wire logic acc = wb_cyc_i & wb_stb_i & ~ack_q;
    // Writes land at the edge where the master samples ack high
    wire logic wr = wb_cyc_i & wb_stb_i & ack_q & wb_we_i & wb_sel_i[0];
    wire logic [7:0] idx = wb_adr_i[`T2C_IDX_MSB:`T2C_IDX_LSB];
    wire logic [7:0] wbyte = wb_dat_i[`T2C_BYTE_MSB:0];
    wire logic wr_ctrl = wr & (idx == `T2C_IDX_CTRL);
    wire logic wr_rlo = wr & (idx == `T2C_IDX_RCAP_LO);
    wire logic wr_rhi = wr & (idx == `T2C_IDX_RCAP_HI);
    wire logic wr_clo = wr & (idx == `T2C_IDX_CNT_LO);
    wire logic wr_chi = wr & (idx == `T2C_IDX_CNT_HI);
    wire logic wr_cnt = wr_clo | wr_chi;
    wire logic wr_rcap = wr_rlo | wr_rhi;
    assign ctrl_wr = t2c_ctrl_t'(wbyte);

    // Read data selection, unmapped reads as zero
    assign rdat_d = (idx == `T2C_IDX_CTRL) ? {`T2C_RD_PAD, ctrl_q} :
                    (idx == `T2C_IDX_RCAP_LO) ? {`T2C_RD_PAD, rcap_q[`T2C_BYTE_MSB:0]} :
                    (idx == `T2C_IDX_RCAP_HI) ? {`T2C_RD_PAD, rcap_q[`T2C_HI_MSB:`T2C_HI_LSB]} :
                    (idx == `T2C_IDX_CNT_LO) ? {`T2C_RD_PAD, count_q[`T2C_BYTE_MSB:0]} :
                    (idx == `T2C_IDX_CNT_HI) ? {`T2C_RD_PAD, count_q[`T2C_HI_MSB:`T2C_HI_LSB]} :
                    {`T2C_RD_PAD, `T2C_CTRL_RST};

    // ----------------------------------------------------------------
    // Count source and events
    // ----------------------------------------------------------------
    wire logic cnt_fall = cnt_pin_q & ~count_pin_i;
    wire logic trg_fall = trg_pin_q & ~trigger_pin_i;
    wire logic baud_mode = ctrl_q.rx_clock_select | ctrl_q.tx_clock_select;
    // Prescaler gives one tick per two clocks in timer mode
    wire logic tick = ctrl_q.counter_timer_select ? cnt_fall : pre_q;
    wire logic inc = ctrl_q.run_control & tick;
    wire logic ovf = inc & (count_q == `T2C_CNT_MAX);
    wire logic trig_ev = ctrl_q.trigger_pin_enable & ~baud_mode & trg_fall;
    wire logic do_reload = (ovf & (baud_mode | ~ctrl_q.capture_reload_select))
                         | (trig_ev & ~ctrl_q.capture_reload_select);
    wire logic do_capture = trig_ev & ctrl_q.capture_reload_select;

    // Next count: reload, else step, then software byte writes win
    assign count_nx = do_reload ? rcap_q : (inc ? count_q + `T2C_CNT_STEP : count_q);
    assign count_d = {wr_chi ? wbyte : count_nx[`T2C_HI_MSB:`T2C_HI_LSB],
                      wr_clo ? wbyte : count_nx[`T2C_BYTE_MSB:0]};

    // Reload/capture pair, capture loads the running count
    assign rcap_d = {wr_rhi ? wbyte : (do_capture ? count_q[`T2C_HI_MSB:`T2C_HI_LSB]
                                                  : rcap_q[`T2C_HI_MSB:`T2C_HI_LSB]),
                     wr_rlo ? wbyte : (do_capture ? count_q[`T2C_BYTE_MSB:0]
                                                  : rcap_q[`T2C_BYTE_MSB:0])};

    // Control next value, hardware set beats software clear
    assign ctrl_d.overflow_flag = (ovf & ~baud_mode)
                                | (wr_ctrl ? ctrl_wr.overflow_flag : ctrl_q.overflow_flag);
    assign ctrl_d.external_edge_flag = trig_ev
                                | (wr_ctrl ? ctrl_wr.external_edge_flag
                                           : ctrl_q.external_edge_flag);
    assign ctrl_d.rx_clock_select = wr_ctrl ? ctrl_wr.rx_clock_select : ctrl_q.rx_clock_select;
    assign ctrl_d.tx_clock_select = wr_ctrl ? ctrl_wr.tx_clock_select : ctrl_q.tx_clock_select;
    assign ctrl_d.trigger_pin_enable = wr_ctrl ? ctrl_wr.trigger_pin_enable
                                               : ctrl_q.trigger_pin_enable;
    assign ctrl_d.run_control = wr_ctrl ? ctrl_wr.run_control : ctrl_q.run_control;
    assign ctrl_d.counter_timer_select = wr_ctrl ? ctrl_wr.counter_timer_select
                                                 : ctrl_q.counter_timer_select;
    assign ctrl_d.capture_reload_select = wr_ctrl ? ctrl_wr.capture_reload_select
                                                  : ctrl_q.capture_reload_select;

    // Serial clock selection per direction
    assign baud_d.rx_tick = ctrl_q.rx_clock_select ? ovf : timer1_ovf_i;
    assign baud_d.tx_tick = ctrl_q.tx_clock_select ? ovf : timer1_ovf_i;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_q <= t2c_ctrl_t'(`T2C_CTRL_RST);
            count_q <= `T2C_WORD_RST;
            rcap_q <= `T2C_WORD_RST;
            pre_q <= 1'b0;
            cnt_pin_q <= 1'b1;
            trg_pin_q <= 1'b1;
            baud_q <= '0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            count_q <= count_d;
            rcap_q <= rcap_d;
            pre_q <= ~pre_q;
            cnt_pin_q <= count_pin_i;
            trg_pin_q <= trigger_pin_i;
            baud_q <= baud_d;
        end
    end

    // Bus answer one cycle after the strobe
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            ack_q <= acc;
            wb_dat_o <= acc ? rdat_d : 32'h00000000;
        end
    end

    // Flop outputs
    assign wb_ack_o = ack_q;
    assign rx_baud_tick_o = baud_q.rx_tick;
    assign tx_baud_tick_o = baud_q.tx_tick;
    assign overflow_flag_o = ctrl_q.overflow_flag;
    assign external_edge_flag_o = ctrl_q.external_edge_flag;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    a_ovf_sets_flag: assert property (ovf && !baud_mode |=> ctrl_q.overflow_flag)
        else $error("overflow did not set flag");
    a_ovf_baud_quiet: assert property (ovf && baud_mode && !wr_ctrl && !ctrl_q.overflow_flag
        |=> !ctrl_q.overflow_flag)
        else $error("overflow flag set in baud mode");
    a_ovf_flag_held: assert property (ctrl_q.overflow_flag && !wr_ctrl
        |=> ctrl_q.overflow_flag)
        else $error("overflow flag cleared by hardware");
    a_ext_flag_set: assert property (trig_ev |=> ctrl_q.external_edge_flag)
        else $error("trigger edge did not set external flag");
    a_ext_flag_held: assert property (ctrl_q.external_edge_flag && !wr_ctrl
        |=> ctrl_q.external_edge_flag)
        else $error("external flag cleared by hardware");
    a_rx_clock_pick: assert property (1'b1 |=> rx_baud_tick_o ==
        ($past(ctrl_q.rx_clock_select) ? $past(ovf) : $past(timer1_ovf_i)))
        else $error("receive clock wrong source");
    a_tx_clock_pick: assert property (1'b1 |=> tx_baud_tick_o ==
        ($past(ctrl_q.tx_clock_select) ? $past(ovf) : $past(timer1_ovf_i)))
        else $error("transmit clock wrong source");
    a_trig_ignored: assert property (trg_fall && (!ctrl_q.trigger_pin_enable || baud_mode)
        && !wr_cnt && !wr_rcap && !inc |=> $stable(count_q) && $stable(rcap_q))
        else $error("disabled trigger changed timer");
    a_stop_holds: assert property (!ctrl_q.run_control && !do_reload && !wr_cnt
        |=> $stable(count_q))
        else $error("stopped timer changed count");
    a_timer_rate: assert property (ctrl_q.run_control && !ctrl_q.counter_timer_select
        && !wr_ctrl && !wr_cnt && !do_reload && !ovf && pre_q
        |=> count_q == $past(count_q) + `T2C_CNT_STEP ##1 $stable(count_q))
        else $error("timer mode rate wrong");
    a_capture_load: assert property (do_capture && !wr_rcap
        |=> rcap_q == $past(count_q))
        else $error("capture missed count");
    a_baud_reload: assert property (ovf && baud_mode && !wr_cnt
        |=> count_q == $past(rcap_q))
        else $error("baud mode overflow did not reload");
    a_bus_answer: assert property (acc |=> s_ack_pulse)
        else $error("bus ack not a single pulse");

endmodule
`default_nettype wire

// file: logic/t2c_defs.svh
// Register indices, field positions, reset values and counts for the timer two block
`ifndef T2C_DEFS_SVH
`define T2C_DEFS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define T2C_IDX_CTRL 8'hC8
`define T2C_IDX_RCAP_LO 8'hCA
`define T2C_IDX_RCAP_HI 8'hCB
`define T2C_IDX_CNT_LO 8'hCC
`define T2C_IDX_CNT_HI 8'hCD

// ----------------------------------------------------------------
// Bus geometry
// ----------------------------------------------------------------
`define T2C_ADR_W 10
`define T2C_IDX_MSB 9
`define T2C_IDX_LSB 2
`define T2C_BYTE_MSB 7
`define T2C_HI_MSB 15
`define T2C_HI_LSB 8
`define T2C_RD_PAD 24'h000000

// ----------------------------------------------------------------
// Reset values and counter limits
// ----------------------------------------------------------------
`define T2C_CTRL_RST 8'h00
`define T2C_WORD_RST 16'h0000
`define T2C_CNT_MAX 16'hFFFF
`define T2C_CNT_STEP 16'h0001

`endif

// file: logic/t2c_pkg.sv
// Types shared by the timer two control block
`default_nettype none
package t2c_pkg;

    // Control register layout, most significant bit first
    typedef struct packed {
        logic overflow_flag;
        logic external_edge_flag;
        logic rx_clock_select;
        logic tx_clock_select;
        logic trigger_pin_enable;
        logic run_control;
        logic counter_timer_select;
        logic capture_reload_select;
    } t2c_ctrl_t;

    // Serial baud tick pair
    typedef struct packed {
        logic rx_tick;
        logic tx_tick;
    } t2c_baud_t;

endpackage
`default_nettype wire

// file: dv/t2c_pins_model.sv
// Far-side model: count pin, trigger pin and the other timer's overflow pulse
`timescale 1ns/1ps
`default_nettype none
module t2c_pins_model
    import t2c_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Pins toward the timer
    output logic count_pin_o,
    output logic trigger_pin_o,
    output logic timer1_ovf_o
);
    // Idle levels: pins high, overflow pulse low
    initial
    begin
        count_pin_o = 1'b1;
        trigger_pin_o = 1'b1;
        timer1_ovf_o = 1'b0;
    end
    // Falling edges on the count pin, two cycles low and two high each
    task automatic fall_count(input int n);
        repeat (n)
        begin
            @(posedge clk_i);
            count_pin_o <= 1'b0;
            repeat (2) @(posedge clk_i);
            count_pin_o <= 1'b1;
            @(posedge clk_i);
        end
    endtask
    // One falling edge on the trigger pin
    task automatic fall_trig();
        @(posedge clk_i);
        trigger_pin_o <= 1'b0;
        repeat (2) @(posedge clk_i);
        trigger_pin_o <= 1'b1;
        repeat (2) @(posedge clk_i);
    endtask
    // One-cycle overflow pulse of the other timer
    task automatic pulse_t1();
        @(posedge clk_i);
        timer1_ovf_o <= 1'b1;
        @(posedge clk_i);
        timer1_ovf_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

// file: dv/tb_timer2_capture_reload_control.sv
// Testbench for the timer two control block
`timescale 1ns/1ps
`default_nettype none
`include "t2c_defs.svh"
module tb_timer2_capture_reload_control
    import t2c_pkg::*;
;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [9:0] adr = 10'h000;
    logic [31:0] wdat = 32'h00000000, rdat, rx_n = 32'h0, tx_n = 32'h0, r0, t0, rs;
    logic ack, cpin, tpin, t1o, rxt, txt, ovf, exf;
    int err_total = 0, tests_run = 0;
    logic [7:0] sv [2] = '{8'h25, 8'h15};
    // ----------------------------------------------------------------
    // Clock, design and far side
    // ----------------------------------------------------------------
    always #12.5 clk_i = ~clk_i;
    t2c_timer u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .count_pin_i(cpin), .trigger_pin_i(tpin), .timer1_ovf_i(t1o),
        .rx_baud_tick_o(rxt), .tx_baud_tick_o(txt), .overflow_flag_o(ovf),
        .external_edge_flag_o(exf));
    t2c_pins_model u_pins (.clk_i(clk_i), .count_pin_o(cpin), .trigger_pin_o(tpin),
        .timer1_ovf_o(t1o));
    // Baud tick counters
    always @(posedge clk_i)
    begin
        if (rxt === 1'b1) rx_n <= rx_n + 32'h1;
        if (txt === 1'b1) tx_n <= tx_n + 32'h1;
    end
    // ----------------------------------------------------------------
    // Bus tasks and checks
    // ----------------------------------------------------------------
    task automatic close_out();
        if (err_total == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        wdat <= {24'h000000, d};
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        // Bounded wait ran out without an answer
        if (ack !== 1'b1)
        begin
            err_total++;
            close_out();
        end
        r0 = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] keep;
        keep = r0;
        wb(1'b0, idx, 8'h00);
        chk(r0, {24'h000000, exp});
        r0 = keep;
    endtask
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        rc(`T2C_IDX_CTRL, 8'h00);
        rc(`T2C_IDX_RCAP_LO, 8'h00);
        rc(8'h10, 8'h00);
        wb(1'b1, `T2C_IDX_RCAP_LO, 8'h00);
        wb(1'b1, `T2C_IDX_RCAP_HI, 8'hAB);
        rc(`T2C_IDX_RCAP_HI, 8'hAB);
        wb(1'b1, `T2C_IDX_CNT_LO, 8'hF0);
        wb(1'b1, `T2C_IDX_CNT_HI, 8'hFF);
        repeat (40) @(posedge clk_i);
        rc(`T2C_IDX_CNT_LO, 8'hF0);
        wb(1'b1, `T2C_IDX_CTRL, 8'h04);
        repeat (60) @(posedge clk_i);
        rc(`T2C_IDX_CTRL, 8'h84);
        rc(`T2C_IDX_CNT_HI, 8'hAB);
        chk({31'h0, ovf}, 32'h1);
        wb(1'b1, `T2C_IDX_CTRL, 8'h80);
        repeat (20) @(posedge clk_i);
        rc(`T2C_IDX_CTRL, 8'h80);
        wb(1'b1, `T2C_IDX_CTRL, 8'h00);
        rc(`T2C_IDX_CTRL, 8'h00);
        // Serial clock selects: no flag, forced reload, tick on chosen side
        for (int i = 0; i < 2; i++)
        begin
            wb(1'b1, `T2C_IDX_CNT_LO, 8'hF0);
            wb(1'b1, `T2C_IDX_CNT_HI, 8'hFF);
            t0 = tx_n;
            rs = rx_n;
            wb(1'b1, `T2C_IDX_CTRL, sv[i]);
            repeat (60) @(posedge clk_i);
            rc(`T2C_IDX_CTRL, sv[i]);
            rc(`T2C_IDX_CNT_HI, 8'hAB);
            chk(rx_n - rs, {31'h0, sv[i][5]});
            chk(tx_n - t0, {31'h0, sv[i][4]});
            wb(1'b1, `T2C_IDX_CTRL, 8'h00);
        end
        t0 = tx_n;
        rs = rx_n;
        u_pins.pulse_t1();
        repeat (3) @(posedge clk_i);
        chk(rx_n - rs, 32'h1);
        chk(tx_n - t0, 32'h1);
        // Counter mode on count pin edges
        wb(1'b1, `T2C_IDX_CNT_LO, 8'h00);
        wb(1'b1, `T2C_IDX_CNT_HI, 8'h00);
        wb(1'b1, `T2C_IDX_CTRL, 8'h06);
        u_pins.fall_count(3);
        rc(`T2C_IDX_CNT_LO, 8'h03);
        // Capture and reload by trigger pin
        wb(1'b1, `T2C_IDX_CTRL, 8'h01);
        wb(1'b1, `T2C_IDX_CNT_LO, 8'h34);
        wb(1'b1, `T2C_IDX_CNT_HI, 8'h12);
        u_pins.fall_trig();
        rc(`T2C_IDX_CTRL, 8'h01);
        rc(`T2C_IDX_RCAP_HI, 8'hAB);
        wb(1'b1, `T2C_IDX_CTRL, 8'h09);
        u_pins.fall_trig();
        rc(`T2C_IDX_CTRL, 8'h49);
        rc(`T2C_IDX_RCAP_LO, 8'h34);
        rc(`T2C_IDX_RCAP_HI, 8'h12);
        repeat (20) @(posedge clk_i);
        chk({31'h0, exf}, 32'h1);
        wb(1'b1, `T2C_IDX_CTRL, 8'h08);
        wb(1'b1, `T2C_IDX_CNT_HI, 8'h00);
        u_pins.fall_trig();
        rc(`T2C_IDX_CNT_HI, 8'h12);
        rc(`T2C_IDX_CTRL, 8'h48);
        close_out();
    end
endmodule
`default_nettype wire
